// >>> fcr_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module fcr_top
    import fcr_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          reset,
    input  wire fcr_axil_req_t axil_req,
    output fcr_axil_rsp_t      axil_rsp_q,
    input  wire logic          write_protect_n_pin,
    input  wire logic [1:0]    data_rate,
    input  wire logic          drive_sel,
    input  wire logic [1:0]    tape_sel,
    output logic [7:0]         tape_drive_reg_q,
    output logic               density_select_out_q,
    output logic               write_protected_q,
    output logic               legacy_mode_q,
    output logic               pins_oe_n_q
);

    logic [7:0]            reg_q [FCR_NREG];
    logic [FCR_NREG-1:0]   wr_hit;
    logic [FCR_NREG-1:0]   rd_sel;
    logic [FCR_NREG-1:0]   w_match;
    logic [7:0]            rd_part [FCR_NREG];

    logic                  aw_held_q;
    logic                  w_held_q;
    logic [FCR_ADDR_W-1:0] waddr_q;
    logic [7:0]            wbyte_q;
    logic                  wlane_q;
    logic                  wp_meta_q;
    logic                  wp_sync_q;

    // ---------------- write channel ----------------
    wire aw_take  = axil_req.awvalid & axil_rsp_q.awready;
    wire w_take   = axil_req.wvalid & axil_rsp_q.wready;
    wire write_do = aw_held_q & w_held_q & ~axil_rsp_q.bvalid;
    wire aw_held_d = (aw_held_q | aw_take) & ~write_do;
    wire w_held_d  = (w_held_q | w_take) & ~write_do;
    wire bvalid_d  = (axil_rsp_q.bvalid & ~axil_req.bready) | write_do;

    wire [7:0] widx    = waddr_q[9:2];
    wire       wupper0 = (waddr_q[FCR_ADDR_W-1:10] == '0);
    wire       w_dma2  = wupper0 & (widx == FCR_IDX_DMA2_RPT);

    // ---------------- read channel ----------------
    wire ar_take  = axil_req.arvalid & axil_rsp_q.arready;
    wire rvalid_d = (axil_rsp_q.rvalid & ~axil_req.rready) | ar_take;
    wire [7:0] ridx    = axil_req.araddr[9:2];
    wire       rupper0 = (axil_req.araddr[FCR_ADDR_W-1:10] == '0);
    wire       r_dma2  = rupper0 & (ridx == FCR_IDX_DMA2_RPT);
    wire       r_hit   = (|rd_sel) | r_dma2;

    genvar gi;
    generate
        for (gi = 0; gi < FCR_NREG; gi++) begin : g_reg
            assign w_match[gi] = wupper0 & (widx == FCR_IDX[gi]);
            assign wr_hit[gi] = write_do & wlane_q & w_match[gi];
            assign rd_sel[gi] = rupper0 & (ridx == FCR_IDX[gi]);
            assign rd_part[gi] = rd_sel[gi] ? reg_q[gi] : 8'h00;
            // reset values and writable masks per register
            fcr_cfg_byte #(
                .RESET_VAL (FCR_RST[gi]),
                .WR_MASK   (FCR_WMASK[gi])
            ) u_byte (
                .clk_sys (clk_sys),
                .reset   (reset),
                .wr_en   (wr_hit[gi]),
                .wr_data (wbyte_q),
                .q       (reg_q[gi])
            );
        end
    endgenerate

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = r_dma2 ? FCR_DMA2_VALUE : 8'h00;
        for (int i = 0; i < FCR_NREG; i++) begin
            rd_byte = rd_byte | rd_part[i];
        end
    end

    // decoded as wires from the held address; bresp loads the code only on the cycle the write is done
    wire w_mapped = (|w_match) | w_dma2;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            waddr_q   <= '0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            if (aw_take) begin
                waddr_q <= axil_req.awaddr;
            end
            if (w_take) begin
                wbyte_q <= axil_req.wdata[7:0];
                wlane_q <= axil_req.wstrb[0];
            end
        end
    end

    // ready flags registered so every response signal is a flop output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            axil_rsp_q <= '0;
        end else begin
            axil_rsp_q.awready <= ~aw_held_d & ~bvalid_d;
            axil_rsp_q.wready  <= ~w_held_d & ~bvalid_d;
            axil_rsp_q.bvalid  <= bvalid_d;
            if (write_do) begin
                axil_rsp_q.bresp <= w_mapped ? FCR_RESP_OKAY : FCR_RESP_SLVERR;
            end
            axil_rsp_q.arready <= ~rvalid_d;
            axil_rsp_q.rvalid  <= rvalid_d;
            if (ar_take) begin
                axil_rsp_q.rdata <= {24'h000000, rd_byte};
                axil_rsp_q.rresp <= r_hit ? FCR_RESP_OKAY : FCR_RESP_SLVERR;
            end
        end
    end

    // ---------------- floppy side ----------------
    wire [7:0] cfg      = reg_q[FCR_R_CFG];
    wire [7:0] drive_identification = reg_q[FCR_R_DRIVE_IDENTIFICATION];
    wire       active   = reg_q[FCR_R_ACTIVATE][FCR_ACT_BIT];
    wire       high_rate = (data_rate == FCR_RATE_500K) | (data_rate == FCR_RATE_1M);
    wire [1:0] id_pick  = drive_sel ? drive_identification[3:2] : drive_identification[1:0];
    // undriven enhanced bits float, so they read back as ones
    wire [7:0] tdr_enh  = {FCR_TDR_FLOAT, id_pick, FCR_TDR_FLOAT, tape_sel};
    wire [7:0] tdr_leg  = {FCR_TDR_LEGACY_FILL, tape_sel};
    wire [7:0] tdr_d    = cfg[FCR_CFG_ENH] ? tdr_enh : tdr_leg;
    wire       dens_d   = cfg[FCR_CFG_DENS_POL] ? high_rate : ~high_rate;
    wire       wprot_d  = cfg[FCR_CFG_WPROT] | ~wp_sync_q;
    wire       hiz_d    = cfg[FCR_CFG_TRISTATE] & ~active;

    // pin synchroniser; idle level is not protected
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end else begin
            wp_meta_q <= write_protect_n_pin;
            wp_sync_q <= wp_meta_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tape_drive_reg_q     <= 8'hFF;
            density_select_out_q <= 1'b0;
            write_protected_q    <= 1'b1;
            legacy_mode_q        <= 1'b1;
            pins_oe_n_q          <= 1'b0;
        end else begin
            tape_drive_reg_q     <= tdr_d;
            density_select_out_q <= dens_d;
            write_protected_q    <= wprot_d;
            legacy_mode_q        <= cfg[FCR_CFG_LEGACY];
            pins_oe_n_q          <= hiz_d;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_cfg_reset;
        $fell(reset) |-> (cfg == FCR_RST_CFG) && (drive_identification == FCR_RST_DRIVE_IDENTIFICATION)
            && (reg_q[FCR_R_ACTIVATE] == FCR_RST_ACTIVATE);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("bad reset values");

    property p_legacy_fill;
        !cfg[FCR_CFG_ENH] |=> (tape_drive_reg_q[7:2] == FCR_TDR_LEGACY_FILL);
    endproperty
    a_legacy_fill: assert property (p_legacy_fill) else $error("tape bits not ones");

    property p_density;
        1'b1 |=> density_select_out_q ==
            ($past(cfg[FCR_CFG_DENS_POL]) ? $past(high_rate) : !$past(high_rate));
    endproperty
    a_density: assert property (p_density) else $error("density polarity wrong");

    property p_wprot;
        1'b1 |=> write_protected_q == ($past(cfg[FCR_CFG_WPROT]) || !$past(wp_sync_q));
    endproperty
    a_wprot: assert property (p_wprot) else $error("write protect wrong");

    property p_mode;
        $changed(cfg[FCR_CFG_LEGACY]) |=> legacy_mode_q == $past(cfg[FCR_CFG_LEGACY]);
    endproperty
    a_mode: assert property (p_mode) else $error("drive mode not followed");

    property p_hiz;
        1'b1 |=> pins_oe_n_q == ($past(cfg[FCR_CFG_TRISTATE]) && !$past(active));
    endproperty
    a_hiz: assert property (p_hiz) else $error("output enable wrong");

    property p_id_drive1;
        (cfg[FCR_CFG_ENH] && drive_sel) |=> tape_drive_reg_q[5:4] == $past(drive_identification[3:2]);
    endproperty
    a_id_drive1: assert property (p_id_drive1) else $error("drive 1 id wrong");

    property p_id_drive0;
        (cfg[FCR_CFG_ENH] && !drive_sel) |=> tape_drive_reg_q[5:4] == $past(drive_identification[1:0]);
    endproperty
    a_id_drive0: assert property (p_id_drive0) else $error("drive 0 id wrong");

    property p_ro_bits;
        (reg_q[1][7:3] == 5'h00) && (reg_q[2][2] == 1'b0) && (reg_q[2][0] == 1'b0)
            && (reg_q[4][7:2] == 6'h00) && reg_q[4][0] && (drive_identification[7:4] == 4'h0);
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only bit changed");

    sequence s_dma2_req;
        ar_take && r_dma2;
    endsequence
    sequence s_dma2_rsp;
        axil_rsp_q.rvalid && (axil_rsp_q.rdata == {24'h000000, FCR_DMA2_VALUE});
    endsequence
    property p_dma2;
        s_dma2_req |=> s_dma2_rsp;
    endproperty
    a_dma2: assert property (p_dma2) else $error("dma report wrong");

    sequence s_both_held;
        aw_held_q && w_held_q && !axil_rsp_q.bvalid;
    endsequence
    property p_write_resp;
        s_both_held |=> axil_rsp_q.bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");

    // response must stand until the master takes it
    property p_bvalid_stands;
        (axil_rsp_q.bvalid && !axil_req.bready) |=> axil_rsp_q.bvalid;
    endproperty
    a_bvalid_stands: assert property (p_bvalid_stands) else $error("write response dropped");

endmodule

// >>> fcr_pkg.sv
package fcr_pkg;

    localparam int unsigned FCR_ADDR_W = 12;
    localparam int unsigned FCR_DATA_W = 32;
    localparam int unsigned FCR_NREG   = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] FCR_IDX_ACTIVATE  = 8'h30;
    localparam logic [7:0] FCR_IDX_BASE_HI   = 8'h60;
    localparam logic [7:0] FCR_IDX_BASE_LO   = 8'h61;
    localparam logic [7:0] FCR_IDX_IRQ_WAKE  = 8'h70;
    localparam logic [7:0] FCR_IDX_IRQ_TYPE  = 8'h71;
    localparam logic [7:0] FCR_IDX_DMA_SEL   = 8'h74;
    localparam logic [7:0] FCR_IDX_DMA2_RPT  = 8'h75;
    localparam logic [7:0] FCR_IDX_CFG       = 8'hF0;
    localparam logic [7:0] FCR_IDX_DRIVE_IDENTIFICATION  = 8'hF1;

    // positions in the stored register array
    localparam int unsigned FCR_R_ACTIVATE = 0;
    localparam int unsigned FCR_R_CFG      = 6;
    localparam int unsigned FCR_R_DRIVE_IDENTIFICATION = 7;

    localparam logic [7:0] FCR_IDX  [FCR_NREG] = '{
        8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'hF0, 8'hF1};
    localparam logic [7:0] FCR_RST  [FCR_NREG] = '{
        8'h00, 8'h03, 8'hF2, 8'h06, 8'h03, 8'h02, 8'h24, 8'h00};
    // writable bits; all others hold their reset value
    localparam logic [7:0] FCR_WMASK[FCR_NREG] = '{
        8'hFF, 8'h07, 8'hFA, 8'hFF, 8'h02, 8'hFF, 8'h6D, 8'h0F};

    localparam logic [7:0] FCR_RST_ACTIVATE = 8'h00;
    localparam logic [7:0] FCR_RST_CFG      = 8'h24;
    localparam logic [7:0] FCR_RST_DRIVE_IDENTIFICATION = 8'h00;
    localparam logic [7:0] FCR_DMA2_VALUE   = 8'h04;

    // controller configuration fields
    localparam int unsigned FCR_CFG_TRISTATE = 0;
    localparam int unsigned FCR_CFG_LEGACY   = 2;
    localparam int unsigned FCR_CFG_WPROT    = 3;
    localparam int unsigned FCR_CFG_DENS_POL = 5;
    localparam int unsigned FCR_CFG_ENH      = 6;
    localparam int unsigned FCR_ACT_BIT      = 0;

    localparam logic [5:0] FCR_TDR_LEGACY_FILL = 6'h3F;
    localparam logic [1:0] FCR_TDR_FLOAT       = 2'h3;
    localparam logic [1:0] FCR_RATE_500K       = 2'h0;
    localparam logic [1:0] FCR_RATE_1M         = 2'h3;

    localparam logic [1:0] FCR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FCR_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [FCR_ADDR_W-1:0] awaddr;
        logic                  awvalid;
        logic [FCR_DATA_W-1:0] wdata;
        logic [3:0]            wstrb;
        logic                  wvalid;
        logic                  bready;
        logic [FCR_ADDR_W-1:0] araddr;
        logic                  arvalid;
        logic                  rready;
    } fcr_axil_req_t;

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic [1:0]            bresp;
        logic                  bvalid;
        logic                  arready;
        logic [FCR_DATA_W-1:0] rdata;
        logic [1:0]            rresp;
        logic                  rvalid;
    } fcr_axil_rsp_t;

endpackage

// >>> fcr_cfg_byte.sv
`timescale 1ns/1ps
module fcr_cfg_byte
    import fcr_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);

    logic [7:0] q_d;

    // read-only bits keep the reset value forever
    assign q_d = (q & ~WR_MASK) | (wr_data & WR_MASK);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= q_d;
        end
    end

endmodule

// >>> fcr_test.sv
`timescale 1ns/1ps
module fcr_test
    import fcr_pkg::*;
;
    logic          clk_sys;
    logic          reset;
    fcr_axil_req_t req;
    fcr_axil_rsp_t rsp;
    logic          wp_n;
    logic [1:0]    rate;
    logic          dsel;
    logic [1:0]    tsel;
    logic [7:0]    tape_drive_reg;
    logic          dens;
    logic          wprot;
    logic          legacy;
    logic          oe_n;
    int            err_total;
    int            checked;
    int            cycles = 0;
    logic [7:0]    cur [9];
    logic [1:0]    resp;
    logic [31:0]   rd_v;
    logic [7:0]    cfgv;
    logic [7:0]    idv;
    logic [7:0]    actv;

    // bench copy of the register map: index, reset value, writable bits
    localparam logic [7:0] T_IDX [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75,
                                         8'hF0, 8'hF1};
    localparam logic [7:0] T_RST [9] = '{8'h00, 8'h03, 8'hF2, 8'h06, 8'h03, 8'h02, 8'h04,
                                         8'h24, 8'h00};
    localparam logic [7:0] T_WM  [9] = '{8'hFF, 8'h07, 8'hFA, 8'hFF, 8'h02, 8'hFF, 8'h00,
                                         8'h6D, 8'h0F};

    fcr_top uut (
        .clk_sys              (clk_sys),
        .reset                (reset),
        .axil_req             (req),
        .axil_rsp_q           (rsp),
        .write_protect_n_pin  (wp_n),
        .data_rate            (rate),
        .drive_sel            (dsel),
        .tape_sel             (tsel),
        .tape_drive_reg_q     (tape_drive_reg),
        .density_select_out_q (dens),
        .write_protected_q    (wprot),
        .legacy_mode_q        (legacy),
        .pins_oe_n_q          (oe_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, well above the fewer than a thousand cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // both address and data offered at once, each dropped as soon as taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge clk_sys);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!((!req.awvalid || rsp.awready) && (!req.wvalid || rsp.wready)));
        while (!rsp.bvalid) @(posedge clk_sys);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do @(posedge clk_sys); while (!rsp.arready);
        req.arvalid <= 1'b0;
        while (!rsp.rvalid) @(posedge clk_sys);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    task automatic wreg(input int i, input logic [7:0] d, input logic [3:0] s);
        logic [1:0] r;
        wr({2'b00, T_IDX[i], 2'b00}, {24'h0, d}, s, r);
        check({30'h0, r}, {30'h0, FCR_RESP_OKAY});
        if (s[0]) cur[i] = (cur[i] & ~T_WM[i]) | (d & T_WM[i]);
    endtask

    task automatic check_all();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 9; i++) begin
            rd({2'b00, T_IDX[i], 2'b00}, d, r);
            check(d, {24'h0, cur[i]});
            check({30'h0, r}, {30'h0, FCR_RESP_OKAY});
        end
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        cur = T_RST;
    endtask

    function automatic logic [7:0] exp_tdr(logic [7:0] c, logic [7:0] id, logic ds,
                                           logic [1:0] ts);
        logic [1:0] sel;
        sel = ds ? id[3:2] : id[1:0];
        return c[6] ? {2'b11, sel, 2'b11, ts} : {6'h3F, ts};
    endfunction

    initial begin
        reset     = 1'b1;
        req       = '0;
        wp_n      = 1'b1;
        rate      = 2'h0;
        dsel      = 1'b0;
        tsel      = 2'h0;
        err_total = 0;
        checked   = 0;
        void'($urandom(32'h4C0DDD21));
        do_reset();
        check_all();
        $display("test reset values done");

        wr(12'h0C4, 32'h0000_00FF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, FCR_RESP_SLVERR});
        rd(12'h0C4, rd_v, resp);
        check(rd_v, 32'h0);
        check({30'h0, resp}, {30'h0, FCR_RESP_SLVERR});
        for (int i = 0; i < 9; i++) begin
            wreg(i, (i == 7) ? 8'h6F : 8'hFF, 4'h1);
            wreg(i, 8'h00, 4'hE);
        end
        check_all();
        for (int k = 0; k < 40; k++) begin
            int i;
            i = $urandom_range(8);
            cfgv = 8'($urandom);
            if (i == 7) cfgv = cfgv & 8'h6F;
            wreg(i, cfgv, 4'($urandom));
        end
        check_all();
        $display("test register access done");

        for (int k = 0; k < 30; k++) begin
            cfgv = 8'($urandom) & 8'h6F;
            idv  = 8'($urandom) & 8'h0F;
            // half the runs model drives without media sense
            if (k[0]) idv = idv | 8'h0A;
            actv = 8'($urandom);
            if (k == 0) begin
                cfgv = 8'h69;
                actv = 8'h00;
            end
            wreg(7, cfgv, 4'h1);
            wreg(8, idv, 4'h1);
            wreg(0, actv, 4'h1);
            @(posedge clk_sys);
            wp_n <= 1'($urandom);
            rate <= 2'($urandom);
            dsel <= 1'($urandom);
            tsel <= 2'($urandom);
            // synchroniser on the protect pin needs the extra cycles
            repeat (4) @(posedge clk_sys);
            check({24'h0, tape_drive_reg}, {24'h0, exp_tdr(cfgv, idv, dsel, tsel)});
            check({31'h0, dens}, {31'h0, cfgv[5] ~^ (rate == 2'h0 || rate == 2'h3)});
            check({31'h0, wprot}, {31'h0, cfgv[3] | ~wp_n});
            check({31'h0, legacy}, {31'h0, cfgv[2]});
            check({31'h0, oe_n}, {31'h0, cfgv[0] & ~actv[0]});
        end
        $display("test drive outputs done");

        do_reset();
        check_all();
        $display("test second reset done");
        results();
    end
endmodule
